// File: pwg_pkg.sv
// Package: register map, field positions, reset values and mode codes of the PWM generator
package pwg_pkg;

  // Register byte offsets
  localparam logic [7:0] PWG_CTRL_OFS = 8'h00;
  localparam logic [7:0] PWG_PRESC_OFS = 8'h04;
  localparam logic [7:0] PWG_TOP_OFS = 8'h08;
  localparam logic [7:0] PWG_COUNT_OFS = 8'h0C;
  localparam logic [7:0] PWG_STATUS_OFS = 8'h10;
  localparam logic [7:0] PWG_MODE_OFS = 8'h14;
  localparam logic [7:0] PWG_DEAD_OFS = 8'h18;
  localparam logic [7:0] PWG_PORT_OFS = 8'h1C;
  localparam logic [7:0] PWG_DDR_OFS = 8'h20;
  localparam logic [7:0] PWG_COMP_OFS = 8'h24;
  localparam int PWG_COMP_STRIDE = 4;

  // Control register fields
  localparam int PWG_CTRL_EN_LSB = 0;
  localparam int PWG_CTRL_SLOPE_BIT = 4;
  localparam int PWG_CTRL_RUN_BIT = 5;
  localparam int PWG_CTRL_TOG_LSB = 8;

  // Dead time fields, in timer ticks
  localparam int PWG_DEAD_LO_LSB = 0;
  localparam int PWG_DEAD_HI_LSB = 4;
  localparam int PWG_DEAD_W = 4;

  // Status fields
  localparam int PWG_STAT_OVF_BIT = 0;

  // Reset values
  localparam logic [7:0] PWG_TOP_RST = 8'hFF;
  localparam logic [7:0] PWG_COMP_RST = 8'h00;
  localparam logic [7:0] PWG_PRESC_RST = 8'h00;

  // Compare output mode codes
  typedef enum logic [1:0] {
    PWG_COM_OFF = 2'h0,
    PWG_COM_COMPL = 2'h1,
    PWG_COM_NONINV = 2'h2,
    PWG_COM_INV = 2'h3
  } pwg_com_t;

endpackage

// File: pwg_top.sv
// PWM generator: shared single/dual slope counter, compare channels, dead time and pin override
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module pwg_top
  import pwg_pkg::*;
#(
  parameter int NCH = 3,
  parameter int CW = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins: bit 2i true output, bit 2i+1 inverted output of channel i
  output logic [2*NCH-1:0] pin_o,
  output logic [2*NCH-1:0] pin_oe_o,
  // Status
  output logic overflow_flag_o
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (dat & m);
  endfunction
  function automatic logic [7:0] comp_ofs(input int idx);
    return 8'(int'(PWG_COMP_OFS) + PWG_COMP_STRIDE * idx);
  endfunction
  // Register state
  logic [31:0] ctrl_q, ctrl_d;
  logic [7:0] presc_q, presc_d;
  logic [CW-1:0] top_q, top_d;
  logic [2*NCH-1:0] mode_q, mode_d;
  logic [2*PWG_DEAD_W-1:0] dead_q, dead_d;
  logic [2*NCH-1:0] port_q, port_d;
  logic [2*NCH-1:0] ddr_q, ddr_d;
  logic [CW-1:0] comp_q [NCH];
  logic [CW-1:0] comp_d [NCH];
  logic ovf_q, ovf_d;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;

  // Timer state
  logic [7:0] pcnt_q, pcnt_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic up_q, up_d;
  logic tick, any_en, slope, wrap, bottom, ovf_set;

  // Channel state
  logic [NCH-1:0] wave_q, wave_d;
  logic [NCH-1:0] wave_p_q, wave_p_d;
  logic [2*NCH-1:0] act_q, act_d;
  logic [PWG_DEAD_W-1:0] dt_q [NCH];
  logic [PWG_DEAD_W-1:0] dt_d [NCH];
  logic [NCH-1:0] oct_q, oct_d;
  logic [NCH-1:0] ocn_q, ocn_d;
  logic [2*NCH-1:0] pin_d, pin_oe_d;

  logic req, wr;
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = req & wb_we_i;
  // Bus register file
  always_comb begin
    ctrl_d = ctrl_q;
    presc_d = presc_q;
    top_d = top_q;
    mode_d = mode_q;
    dead_d = dead_q;
    port_d = port_q;
    ddr_d = ddr_q;
    comp_d = comp_q;
    ovf_d = ovf_q;
    ack_d = req;
    dat_d = dat_q;
    if (req) begin
      dat_d = 32'h0;
      case (wb_adr_i)
        PWG_CTRL_OFS: dat_d = ctrl_q;
        PWG_PRESC_OFS: dat_d = 32'(presc_q);
        PWG_TOP_OFS: dat_d = 32'(top_q);
        PWG_COUNT_OFS: dat_d = 32'(cnt_q);
        PWG_STATUS_OFS: dat_d = 32'(ovf_q);
        PWG_MODE_OFS: dat_d = 32'(mode_q);
        PWG_DEAD_OFS: dat_d = 32'(dead_q);
        PWG_PORT_OFS: dat_d = 32'(port_q);
        PWG_DDR_OFS: dat_d = 32'(ddr_q);
        default: dat_d = 32'h0;
      endcase
      for (int i = 0; i < NCH; i++) begin
        if (wb_adr_i == comp_ofs(i)) begin
          dat_d = 32'(comp_q[i]);
        end
      end
    end
    if (wr) begin
      case (wb_adr_i)
        PWG_CTRL_OFS: ctrl_d = merge(ctrl_q, wb_dat_i, wb_sel_i);
        PWG_PRESC_OFS: presc_d = 8'(merge(32'(presc_q), wb_dat_i, wb_sel_i));
        PWG_TOP_OFS: top_d = CW'(merge(32'(top_q), wb_dat_i, wb_sel_i));
        PWG_MODE_OFS: mode_d = (2*NCH)'(merge(32'(mode_q), wb_dat_i, wb_sel_i));
        PWG_DEAD_OFS: dead_d = (2*PWG_DEAD_W)'(merge(32'(dead_q), wb_dat_i, wb_sel_i));
        PWG_PORT_OFS: port_d = (2*NCH)'(merge(32'(port_q), wb_dat_i, wb_sel_i));
        PWG_DDR_OFS: ddr_d = (2*NCH)'(merge(32'(ddr_q), wb_dat_i, wb_sel_i));
        PWG_STATUS_OFS: begin
          if (wb_sel_i[0] && wb_dat_i[PWG_STAT_OVF_BIT]) begin
            ovf_d = 1'b0;
          end
        end
        default: ;
      endcase
      for (int i = 0; i < NCH; i++) begin
        if (wb_adr_i == comp_ofs(i)) begin
          comp_d[i] = CW'(merge(32'(comp_q[i]), wb_dat_i, wb_sel_i));
        end
      end
    end
    // Set wins over a same-cycle clear
    if (ovf_set) begin
      ovf_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= 32'h0;
      presc_q <= PWG_PRESC_RST;
      top_q <= CW'(PWG_TOP_RST);
      mode_q <= '0;
      dead_q <= '0;
      port_q <= '0;
      ddr_q <= '0;
      for (int i = 0; i < NCH; i++) begin
        comp_q[i] <= CW'(PWG_COMP_RST);
      end
      ovf_q <= 1'b0;
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ctrl_q <= ctrl_d;
      presc_q <= presc_d;
      top_q <= top_d;
      mode_q <= mode_d;
      dead_q <= dead_d;
      port_q <= port_d;
      ddr_q <= ddr_d;
      comp_q <= comp_d;
      ovf_q <= ovf_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  // Timer clock enable and shared counter
  always_comb begin
    any_en = |ctrl_q[PWG_CTRL_EN_LSB +: NCH];
    slope = ctrl_q[PWG_CTRL_SLOPE_BIT];
    tick = ctrl_q[PWG_CTRL_RUN_BIT] && any_en && (pcnt_q == presc_q);
    pcnt_d = (ctrl_q[PWG_CTRL_RUN_BIT] && any_en && !tick) ? pcnt_q + 8'h01 : 8'h00;
    wrap = !slope && (cnt_q == top_q);
    bottom = slope && (cnt_q == '0);
    cnt_d = cnt_q;
    up_d = up_q;
    ovf_set = 1'b0;
    if (tick) begin
      if (!slope) begin
        up_d = 1'b1;
        if (wrap) begin
          cnt_d = '0;
          ovf_set = 1'b1;
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end else if (top_q == '0) begin
        cnt_d = '0;
        up_d = 1'b1;
        ovf_set = 1'b1;
      end else if (up_q) begin
        if (cnt_q == top_q) begin
          cnt_d = top_q - CW'(1);
          up_d = 1'b0;
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end else begin
        if (cnt_q == CW'(1)) begin
          ovf_set = 1'b1;
        end
        if (cnt_q == '0) begin
          cnt_d = CW'(1);
          up_d = 1'b1;
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pcnt_q <= 8'h00;
      cnt_q <= '0;
      up_q <= 1'b1;
    end else begin
      pcnt_q <= pcnt_d;
      cnt_q <= cnt_d;
      up_q <= up_d;
    end
  end

  // Waveform, dead time and pin override per channel
  always_comb begin
    logic match;
    logic [1:0] eff;
    wave_d = wave_q;
    wave_p_d = wave_p_q;
    act_d = act_q;
    dt_d = dt_q;
    oct_d = oct_q;
    ocn_d = ocn_q;
    match = 1'b0;
    eff = 2'h0;
    for (int i = 0; i < NCH; i++) begin
      match = (cnt_q == comp_q[i]);
      // New mode is picked up only at a match
      eff = match ? mode_q[2*i +: 2] : act_q[2*i +: 2];
      if (tick && ctrl_q[PWG_CTRL_EN_LSB + i]) begin
        act_d[2*i +: 2] = eff;
        case (eff)
          PWG_COM_NONINV: begin
            if (wrap) wave_d[i] = 1'b1;
            else if (match) wave_d[i] = slope ? !up_q : 1'b0;
          end
          PWG_COM_INV: begin
            if (wrap) wave_d[i] = 1'b0;
            else if (match) wave_d[i] = slope ? up_q : 1'b1;
          end
          PWG_COM_COMPL: begin
            if (ctrl_q[PWG_CTRL_TOG_LSB + i]) begin
              if (match) wave_d[i] = !wave_q[i];
            end else if (wrap || bottom) begin
              wave_d[i] = 1'b1;
            end else if (match) begin
              wave_d[i] = 1'b0;
            end
          end
          default: ;
        endcase
        wave_p_d[i] = wave_q[i];
        if (act_q[2*i +: 2] == PWG_COM_COMPL) begin
          // Both sides low while the delay runs out
          if (wave_q[i] != wave_p_q[i]) begin
            dt_d[i] = wave_q[i] ? dead_q[PWG_DEAD_HI_LSB +: PWG_DEAD_W] : dead_q[PWG_DEAD_LO_LSB +: PWG_DEAD_W];
            oct_d[i] = 1'b0;
            ocn_d[i] = 1'b0;
          end else if (dt_q[i] != '0) begin
            dt_d[i] = dt_q[i] - PWG_DEAD_W'(1);
          end else begin
            oct_d[i] = wave_q[i];
            ocn_d[i] = !wave_q[i];
          end
        end else begin
          dt_d[i] = '0;
          oct_d[i] = wave_q[i];
          ocn_d[i] = !wave_q[i];
        end
      end
    end
  end

  // Pin source: compare output whenever its active mode (picked up at a match) is set (inverted pin: mode one only); direction sets only the enables
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      pin_d[2*i] = (act_q[2*i +: 2] != PWG_COM_OFF) ? oct_q[i] : port_q[2*i];
      pin_d[2*i+1] = (act_q[2*i +: 2] == PWG_COM_COMPL) ? ocn_q[i] : port_q[2*i+1];
    end
    pin_oe_d = ddr_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wave_q <= '0;
      wave_p_q <= '0;
      act_q <= '0;
      for (int i = 0; i < NCH; i++) begin
        dt_q[i] <= '0;
      end
      oct_q <= '0;
      ocn_q <= '0;
      pin_o <= '0;
      pin_oe_o <= '0;
    end else begin
      wave_q <= wave_d;
      wave_p_q <= wave_p_d;
      act_q <= act_d;
      dt_q <= dt_d;
      oct_q <= oct_d;
      ocn_q <= ocn_d;
      pin_o <= pin_d;
      pin_oe_o <= pin_oe_d;
    end
  end

  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;
  assign overflow_flag_o = ovf_q;
endmodule // pwg_top
`default_nettype wire

// File: pwg_top_chk.sv
// Port checker for the PWM generator
`timescale 1ns/1ps
`default_nettype none
module pwg_top_chk
  import pwg_pkg::*;
#(
  parameter int NCH = 3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Pins and flag
  input wire logic [2*NCH-1:0] pin_o,
  input wire logic [2*NCH-1:0] pin_oe_o,
  input wire logic overflow_flag_o
);
  logic clr_w;
  assign clr_w = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == PWG_STATUS_OFS;
  // Direction word of the last taken write, for the enable check
  logic [2*NCH-1:0] ddr_val_q;
  always_ff @(posedge clk_i) begin
    if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == PWG_DDR_OFS && wb_sel_i[0]) begin
      ddr_val_q <= wb_dat_i[2*NCH-1:0];
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ddr_wr_s;
    req_s ##0 (wb_we_i && wb_adr_i == PWG_DDR_OFS && wb_sel_i[0]);
  endsequence
  property oe_follow_p;
    ddr_wr_s |-> ##2 pin_oe_o == ddr_val_q;
  endproperty
  ack_timely_a: assert property (req_s |=> wb_ack_o) else $error("ack missing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
  dat_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o) else $error("read data moved");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h2C |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  rst_clean_a: assert property ($fell(rst_i) |-> (pin_o == '0 && !overflow_flag_o && !wb_ack_o) [*2])
    else $error("outputs not cleared by reset");
  oe_follow_a: assert property (oe_follow_p) else $error("enables do not follow direction");
  ovf_sticky_a: assert property (overflow_flag_o && !clr_w |=> overflow_flag_o)
    else $error("flag dropped uncleared");
endmodule // pwg_top_chk
`default_nettype wire

// File: pwg_load.sv
// Load model: pulled-down pin lines and high-time counters of channel 0
`timescale 1ns/1ps
`default_nettype none
module pwg_load #(
  parameter int NCH = 3
) (
  // Clock and window restart
  input wire logic clk_i,
  input wire logic clr_i,
  // Generator pins
  input wire logic [2*NCH-1:0] pin_i,
  input wire logic [2*NCH-1:0] oe_i,
  // Observations
  output logic [2*NCH-1:0] line_o,
  output logic [7:0] hi_t_o,
  output logic [7:0] hi_n_o,
  output logic both_o
);
  // Undriven lines sink to the pull-down
  assign line_o = pin_i & oe_i;
  always_ff @(posedge clk_i) begin
    if (clr_i) begin
      hi_t_o <= 8'h00;
      hi_n_o <= 8'h00;
      both_o <= 1'h0;
    end else begin
      hi_t_o <= hi_t_o + 8'(line_o[0]);
      hi_n_o <= hi_n_o + 8'(line_o[1]);
      both_o <= both_o | (line_o[0] & line_o[1]);
    end
  end
endmodule // pwg_load
`default_nettype wire

// File: pwg_top_bench.sv
// Register-level tests of the PWM generator driving a load model
`timescale 1ns/1ps
`default_nettype none
module pwg_top_bench;
  import pwg_pkg::*;
  logic clk, rst, cyc, stb, we, ack, ovf, clr, both;
  logic [7:0] adr, hi_t, hi_n;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [5:0] pin, oe, line;
  int error_cnt = 0;
  int checks_done = 0;
  pwg_com_t md[7] = '{PWG_COM_NONINV, PWG_COM_INV, PWG_COM_NONINV, PWG_COM_INV, PWG_COM_COMPL, PWG_COM_COMPL,
    PWG_COM_COMPL};
  logic slp[7] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0};
  logic tg[7] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
  logic [7:0] cmp[7] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h02, 8'h01};
  // Mode one keeps both sides low for one tick after every edge
  logic [7:0] et[7] = '{8'h06, 8'h12, 8'h08, 8'h10, 8'h06, 8'h04, 8'h09};
  logic [7:0] en[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h06, 8'h0C, 8'h09};
  pwg_top dut_u (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pin_o(pin), .pin_oe_o(oe),
    .overflow_flag_o(ovf));
  pwg_load load_u (.clk_i(clk), .clr_i(clr), .pin_i(pin), .oe_i(oe), .line_o(line), .hi_t_o(hi_t),
    .hi_n_o(hi_n), .both_o(both));
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Called just after an edge; holds the request until ack is sampled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      $display("FAIL bus ack expected 1 seen %b", ack);
      print_verdict();
    end else begin
      q = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      @(posedge clk);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    xfer(1'h0, a, 32'h0);
    check(nm, exp, q);
  endtask
  // Settle, then count 24 cycles: whole periods of both slopes at top 3
  task automatic measure;
    repeat (16) @(posedge clk);
    clr <= 1'h1;
    @(posedge clk);
    clr <= 1'h0;
    repeat (25) @(posedge clk);
  endtask
  initial begin
    {rst, cyc, stb, we, clr} = 5'h10;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    check("pins after reset", 32'h0, {26'h0, pin});
    rd(PWG_TOP_OFS, {24'h0, PWG_TOP_RST}, "top");
    rd(PWG_STATUS_OFS, 32'h0, "status");
    rd(8'h40, 32'h0, "unmapped");
    $display("reset test done");
    xfer(1'h1, PWG_TOP_OFS, 32'h3);
    xfer(1'h1, PWG_DDR_OFS, 32'h3F);
    for (int i = 0; i < 7; i++) begin
      xfer(1'h1, PWG_COMP_OFS, {24'h0, cmp[i]});
      xfer(1'h1, PWG_MODE_OFS, {30'h0, md[i]});
      xfer(1'h1, PWG_CTRL_OFS, {23'h0, tg[i], 2'h0, 1'h1, slp[i], 4'h1});
      xfer(1'h1, PWG_STATUS_OFS, 32'h1);
      measure();
      check("true pin high time", {24'h0, et[i]}, {24'h0, hi_t});
      check("inverted pin high time", {24'h0, en[i]}, {24'h0, hi_n});
      check("pair overlap", 32'h0, {31'h0, both});
      rd(PWG_STATUS_OFS, 32'h1, "overflow");
      check("flag output", 32'h1, {31'h0, ovf});
      $display("mode test %0d done", i);
    end
    xfer(1'h1, PWG_DDR_OFS, 32'h0);
    measure();
    check("undriven pin high time", 32'h0, {24'h0, hi_t});
    xfer(1'h1, PWG_PORT_OFS, 32'h0C);
    xfer(1'h1, PWG_DDR_OFS, 32'h3F);
    repeat (4) @(posedge clk);
    check("port pins", 32'h3, {30'h0, line[3:2]});
    xfer(1'h1, PWG_CTRL_OFS, 32'h0);
    xfer(1'h1, PWG_STATUS_OFS, 32'h1);
    rd(PWG_STATUS_OFS, 32'h0, "overflow cleared");
    check("flag output cleared", 32'h0, {31'h0, ovf});
    $display("pin and flag test done");
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    check("pins after second reset", 32'h0, {26'h0, pin});
    rd(PWG_TOP_OFS, {24'h0, PWG_TOP_RST}, "top after second reset");
    $display("second reset test done");
    print_verdict();
  end
endmodule // pwg_top_bench
bind pwg_top pwg_top_chk #(.NCH(NCH)) chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
  .overflow_flag_o(overflow_flag_o));
`default_nettype wire
